// ===== verilog/pmugp_top.sv
// pmu general purpose pins: three pins, APB registers, pad control
// assumes otp defaults presented while otp_valid pulses after reset
`timescale 1ns/1ps
`default_nettype none
module pmugp_top
  import pmugp_pkg::*;
(
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // otp defaults and system state
  input wire logic otp_valid,
  input wire logic [23:0] otp_defaults,
  input wire logic sleep_state,
  input wire logic [2:0] seq_drive_en,
  input wire logic led_channel_a_output,
  // pads
  input wire logic [2:0] pad_in,
  output logic [2:0] pad_out,
  output logic [2:0] pad_oe_n,
  output logic pulldown_en
);
  typedef struct packed {
    logic [2:0][7:0] cfg;
    logic [2:0] out;
    logic [2:0] oe_n;
    logic pden;
    logic [31:0] rdata;
  } pmugp_state_t;
  pmugp_state_t st_q, st_d;

  logic [2:0] pad_level;
  logic wr_acc;
  logic rd_acc;
  logic [1:0] sel;
  logic hit;
  logic [7:0] wmask;
  logic [7:0] rd_byte;
  logic drive;
  logic val;

  // one debounce filter per pin
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_pin
      pmugp_filter u_filter (
        .pclk(pclk),
        .presetn(presetn),
        .long_sel(st_q.cfg[gi][PMUGP_DEB_BIT]),
        .pad_in(pad_in[gi]),
        .level(pad_level[gi])
      );
    end
  endgenerate

  // address decode; zero wait states so pready is always high
  always_comb begin
    hit = 1'b1;
    sel = 2'd0;
    case (paddr)
      PMUGP_PIN1_ADDR: sel = 2'd0;
      PMUGP_PIN2_ADDR: sel = 2'd1;
      PMUGP_PIN3_ADDR: sel = 2'd2;
      default: hit = 1'b0;
    endcase
  end
  assign wr_acc = psel && penable && pwrite && hit && pstrb[0];
  assign rd_acc = psel && !penable && !pwrite;
  assign wmask = (sel == 2'd2) ? PMUGP_WMASK_3 : PMUGP_WMASK_12;

  // next state: registers, pad drive and read data
  always_comb begin
    st_d = st_q;
    rd_byte = st_q.cfg[sel] & wmask;
    rd_byte[PMUGP_LVL_BIT] = pad_level[sel];
    if (otp_valid) begin
      // otp load overrides a concurrent write: it only happens at power-up
      st_d.cfg[0] = otp_defaults[7:0] & PMUGP_WMASK_12;
      st_d.cfg[1] = otp_defaults[15:8] & PMUGP_WMASK_12;
      st_d.cfg[2] = otp_defaults[23:16] & PMUGP_WMASK_3;
    end else if (wr_acc) begin
      st_d.cfg[sel] = pwdata[7:0] & wmask;
    end
    // read data captured in setup, valid during access
    if (rd_acc) begin
      st_d.rdata = hit ? {24'h000000, rd_byte} : 32'h00000000;
    end
    for (int i = 0; i < 3; i++) begin
      // output pins only drive once the sequencer releases them
      drive = st_q.cfg[i][PMUGP_DIR_BIT] && seq_drive_en[i];
      val = st_q.cfg[i][PMUGP_SET_BIT];
      if (i == 2 && st_q.cfg[i][PMUGP_SRC_BIT]) begin
        val = led_channel_a_output;
      end
      if (sleep_state && st_q.cfg[i][PMUGP_SLP_BIT]) begin
        val = 1'b0;
      end
      st_d.out[i] = val;
      st_d.oe_n[i] = !drive;
      if (i == 2 && st_q.cfg[i][PMUGP_ODN_BIT] && val) begin
        st_d.oe_n[i] = 1'b1; // release instead of driving high
      end
    end
    st_d.pden = st_q.cfg[2][PMUGP_PDN_BIT];
  end

  // power-on reset clears everything until otp reloads
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q.cfg <= {3{PMUGP_RESET_VAL}};
      st_q.out <= 3'b000;
      st_q.oe_n <= 3'b111;
      st_q.pden <= 1'b0;
      st_q.rdata <= 32'h00000000;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata = st_q.rdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign pad_out = st_q.out;
  assign pad_oe_n = st_q.oe_n;
  assign pulldown_en = st_q.pden;

  // sleep forces a driving output low one cycle later
  sleep_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    sleep_state && st_q.cfg[0][PMUGP_SLP_BIT] && !otp_valid && !wr_acc |=> pad_out[0] == 1'b0)
    else $error("pin 1 not forced low in sleep");
  direction_in_a: assert property (@(posedge pclk) disable iff (!presetn)
    !st_q.cfg[1][PMUGP_DIR_BIT] |=> pad_oe_n[1])
    else $error("input pin is driving");
  seq_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    !seq_drive_en[0] |=> pad_oe_n[0])
    else $error("pin driven before sequencer release");
  level_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_acc && hit |=> prdata[PMUGP_LVL_BIT] == $past(pad_level[sel]))
    else $error("level bit does not show pad");
  value_out_a: assert property (@(posedge pclk) disable iff (!presetn)
    !sleep_state && !st_q.cfg[0][PMUGP_SLP_BIT] |=> pad_out[0] == $past(st_q.cfg[0][PMUGP_SET_BIT]))
    else $error("pin 1 output differs from value bit");
  reserved_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_acc && paddr == PMUGP_PIN2_ADDR |=> prdata[6:5] == 2'b00 && prdata[3] == 1'b0)
    else $error("reserved bits read nonzero");
  otp_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    otp_valid |=> st_q.cfg[2] == ($past(otp_defaults[23:16]) & PMUGP_WMASK_3))
    else $error("otp defaults not loaded");
  led_source_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_q.cfg[2][PMUGP_SRC_BIT] && !sleep_state |=> pad_out[2] == $past(led_channel_a_output))
    else $error("pin 3 not following led output");
  open_drain_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_q.cfg[2][PMUGP_ODN_BIT] |=> !(pad_out[2] && !pad_oe_n[2]))
    else $error("open-drain pin driven high");
  pulldown_a: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> pulldown_en == $past(st_q.cfg[2][PMUGP_PDN_BIT]))
    else $error("pulldown not following control");

  // sleep force-low on the other two pins
  // pad drive is built from the current register, so a write in flight does not matter
  sleep_low2_a: assert property (@(posedge pclk) disable iff (!presetn)
    sleep_state && st_q.cfg[1][PMUGP_SLP_BIT] |=> pad_out[1] == 1'b0)
    else $error("pin 2 not forced low in sleep");
  sleep_low3_a: assert property (@(posedge pclk) disable iff (!presetn)
    sleep_state && st_q.cfg[2][PMUGP_SLP_BIT] |=> pad_out[2] == 1'b0)
    else $error("pin 3 not forced low in sleep");
  sleep_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    !st_q.cfg[0][PMUGP_SLP_BIT] |=> pad_out[0] == $past(st_q.cfg[0][PMUGP_SET_BIT]))
    else $error("pin 1 output changed by sleep");

  // value bit reaches the pad outside sleep
  // pin 3 only when its source select points at the value bit
  value_out2_a: assert property (@(posedge pclk) disable iff (!presetn)
    !sleep_state |=> pad_out[1] == $past(st_q.cfg[1][PMUGP_SET_BIT]))
    else $error("pin 2 output differs from value bit");
  value_out3_a: assert property (@(posedge pclk) disable iff (!presetn)
    !sleep_state && !st_q.cfg[2][PMUGP_SRC_BIT] |=> pad_out[2] == $past(st_q.cfg[2][PMUGP_SET_BIT]))
    else $error("pin 3 output differs from value bit");

  // direction bit: inputs never drive, released outputs always drive
  // open drain on pin 3 is excluded since it releases a high level
  dir_in1_a: assert property (@(posedge pclk) disable iff (!presetn)
    !st_q.cfg[0][PMUGP_DIR_BIT] |=> pad_oe_n[0])
    else $error("input pin 1 is driving");
  dir_in3_a: assert property (@(posedge pclk) disable iff (!presetn)
    !st_q.cfg[2][PMUGP_DIR_BIT] |=> pad_oe_n[2])
    else $error("input pin 3 is driving");
  dir_out1_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_q.cfg[0][PMUGP_DIR_BIT] && seq_drive_en[0] |=> !pad_oe_n[0])
    else $error("output pin 1 not driving");
  dir_out2_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_q.cfg[1][PMUGP_DIR_BIT] && seq_drive_en[1] |=> !pad_oe_n[1])
    else $error("output pin 2 not driving");
  dir_out3_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_q.cfg[2][PMUGP_DIR_BIT] && seq_drive_en[2] && !st_q.cfg[2][PMUGP_ODN_BIT] |=> !pad_oe_n[2])
    else $error("push-pull pin 3 not driving");

  // sequencer gate on pins 2 and 3
  seq_gate2_a: assert property (@(posedge pclk) disable iff (!presetn)
    !seq_drive_en[1] |=> pad_oe_n[1])
    else $error("pin 2 driven before sequencer release");
  seq_gate3_a: assert property (@(posedge pclk) disable iff (!presetn)
    !seq_drive_en[2] |=> pad_oe_n[2])
    else $error("pin 3 driven before sequencer release");

  // read data: level bit per pin, upper bits zero, unmapped reads zero
  // limitation: the level shown is the filtered one, so it lags the pad
  level_pin1_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_acc && paddr == PMUGP_PIN1_ADDR |=> prdata[PMUGP_LVL_BIT] == $past(pad_level[0]))
    else $error("pin 1 level bit does not show pad");
  level_pin2_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_acc && paddr == PMUGP_PIN2_ADDR |=> prdata[PMUGP_LVL_BIT] == $past(pad_level[1]))
    else $error("pin 2 level bit does not show pad");
  level_pin3_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_acc && paddr == PMUGP_PIN3_ADDR |=> prdata[PMUGP_LVL_BIT] == $past(pad_level[2]))
    else $error("pin 3 level bit does not show pad");
  read_upper_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_acc |=> prdata[31:8] == 24'h000000)
    else $error("read data upper bits nonzero");
  read_unmapped_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_acc && !hit |=> prdata == 32'h00000000)
    else $error("unmapped read returned data");

  // reserved bits never hold a one, so reads cannot leak them
  rsv_pin1_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q.cfg[0] & ~PMUGP_WMASK_12) == 8'h00)
    else $error("pin 1 reserved bits set");
  rsv_pin2_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q.cfg[1] & ~PMUGP_WMASK_12) == 8'h00)
    else $error("pin 2 reserved bits set");
  rsv_pin3_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_q.cfg[2][PMUGP_LVL_BIT] == 1'b0)
    else $error("pin 3 level bit stored");

  // registers change only through the otp load or an accepted write
  // a write without the low byte strobe must leave them alone
  cfg_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !otp_valid && !wr_acc |=> $stable(st_q.cfg))
    else $error("register changed without write or load");
  strobe_skip_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && pwrite && !pstrb[0] && !otp_valid |=> $stable(st_q.cfg))
    else $error("write without byte strobe took effect");
  otp_load1_a: assert property (@(posedge pclk) disable iff (!presetn)
    otp_valid |=> st_q.cfg[0] == ($past(otp_defaults[7:0]) & PMUGP_WMASK_12))
    else $error("pin 1 otp defaults not loaded");
  otp_load2_a: assert property (@(posedge pclk) disable iff (!presetn)
    otp_valid |=> st_q.cfg[1] == ($past(otp_defaults[15:8]) & PMUGP_WMASK_12))
    else $error("pin 2 otp defaults not loaded");
  write_pin1_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_acc && !otp_valid && sel == 2'd0 |=> st_q.cfg[0] == ($past(pwdata[7:0]) & PMUGP_WMASK_12))
    else $error("pin 1 write did not land");
  write_pin3_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_acc && !otp_valid && sel == 2'd2 |=> st_q.cfg[2] == ($past(pwdata[7:0]) & PMUGP_WMASK_3))
    else $error("pin 3 write did not land");

  // pin 3 extras: led in sleep without force, open-drain sink, pulldown off
  led_sleep_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_q.cfg[2][PMUGP_SRC_BIT] && sleep_state && !st_q.cfg[2][PMUGP_SLP_BIT]
    |=> pad_out[2] == $past(led_channel_a_output))
    else $error("pin 3 lost led output in sleep");
  od_sink_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_q.cfg[2][PMUGP_ODN_BIT] && st_q.cfg[2][PMUGP_DIR_BIT] && seq_drive_en[2] && !st_q.cfg[2][PMUGP_SRC_BIT]
    && !st_q.cfg[2][PMUGP_SET_BIT] |=> !pad_oe_n[2] && !pad_out[2])
    else $error("open-drain pin 3 not sinking");
  pulldown_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    !st_q.cfg[2][PMUGP_PDN_BIT] |=> !pulldown_en)
    else $error("pulldown on while disabled");

  // bus answer: zero wait states, error only on unmapped addresses
  pready_high_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel |-> pready)
    else $error("pready low during transfer");
  mapped_ok_a: assert property (@(posedge pclk) disable iff (!presetn)
    hit |-> !pslverr)
    else $error("error flagged on mapped address");
endmodule : pmugp_top
`default_nettype wire

// ===== shared/pmugp_pkg.sv
// package for the pmu general purpose pin block
// assumes a 100 MHz pclk and an APB host with 32-bit data
package pmugp_pkg;
  // register offsets are printed as indices, byte address is four times
  localparam logic [7:0] PMUGP_PIN1_IDX = 8'h41;
  localparam logic [7:0] PMUGP_PIN2_IDX = 8'h42;
  localparam logic [7:0] PMUGP_PIN3_IDX = 8'h43;
  localparam logic [11:0] PMUGP_PIN1_ADDR = 12'h104;
  localparam logic [11:0] PMUGP_PIN2_ADDR = 12'h108;
  localparam logic [11:0] PMUGP_PIN3_ADDR = 12'h10C;
  // field positions
  localparam int PMUGP_SET_BIT = 0;
  localparam int PMUGP_LVL_BIT = 1;
  localparam int PMUGP_DIR_BIT = 2;
  localparam int PMUGP_PDN_BIT = 3;
  localparam int PMUGP_DEB_BIT = 4;
  localparam int PMUGP_ODN_BIT = 5;
  localparam int PMUGP_SRC_BIT = 6;
  localparam int PMUGP_SLP_BIT = 7;
  // writable masks: pins 1 and 2 have reserved bits 6:5 and 3
  localparam logic [7:0] PMUGP_WMASK_12 = 8'h95;
  localparam logic [7:0] PMUGP_WMASK_3 = 8'hFD;
  // value held while power-on reset is asserted, before the otp load
  localparam logic [7:0] PMUGP_RESET_VAL = 8'h00;
  // debounce times
  localparam int PMUGP_CLK_MHZ = 100;
  localparam int PMUGP_DEB_SHORT_US = 94;
  localparam int PMUGP_DEB_LONG_US = 156;
  localparam int PMUGP_DEB_SHORT_CYC = PMUGP_DEB_SHORT_US * PMUGP_CLK_MHZ;
  localparam int PMUGP_DEB_LONG_CYC = PMUGP_DEB_LONG_US * PMUGP_CLK_MHZ;
  localparam int PMUGP_CNT_W = 15;
endpackage : pmugp_pkg

// ===== verilog/pmugp_filter.sv
// one pad input: two-flop synchroniser and debounce filter
// assumes pclk at 100 MHz; the count values default from the package, the top does not override them
`timescale 1ns/1ps
`default_nettype none
module pmugp_filter
  import pmugp_pkg::*;
#(
  parameter logic [PMUGP_CNT_W-1:0] SHORT_CNT = PMUGP_CNT_W'(PMUGP_DEB_SHORT_CYC),
  parameter logic [PMUGP_CNT_W-1:0] LONG_CNT = PMUGP_CNT_W'(PMUGP_DEB_LONG_CYC)
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic long_sel,
  // pad
  input wire logic pad_in,
  output logic level
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic lvl;
    logic [PMUGP_CNT_W-1:0] cnt;
  } pmugp_flt_t;
  pmugp_flt_t st_q, st_d;
  logic [PMUGP_CNT_W-1:0] limit;

  // s1 feeds only s2; the count restarts whenever the level bounces
  always_comb begin
    st_d = st_q;
    limit = long_sel ? LONG_CNT : SHORT_CNT;
    st_d.s1 = pad_in;
    st_d.s2 = st_q.s1;
    if (st_q.s2 == st_q.lvl) begin
      st_d.cnt = '0;
    end else if (st_q.cnt >= limit - PMUGP_CNT_W'(1)) begin
      st_d.lvl = st_q.s2;
      st_d.cnt = '0;
    end else begin
      st_d.cnt = st_q.cnt + PMUGP_CNT_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign level = st_q.lvl;

  // a new level needs the selected stable time
  stable_time_a: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(st_q.lvl) |-> $past(st_q.cnt) >= $past(limit) - PMUGP_CNT_W'(1))
    else $error("filter level changed before debounce time");
endmodule : pmugp_filter
`default_nettype wire

// ===== dv/tb_pmugp_top.sv
// self-checking bench for the pmu general purpose pin block
// assumes pready is tied high and prdata stands through the access phase
`timescale 1ns/1ps
`default_nettype none
module tb_pmugp_top
  import pmugp_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0] pstrb = 4'hF;
  logic otp_valid = 1'b0, sleep_state = 1'b0, led_channel_a_output = 1'b0;
  logic pready, pslverr, pulldown_en, err;
  logic [23:0] otp_defaults = 24'h0;
  logic [2:0] seq_drive_en = 3'h0, pad_in = 3'h0, pad_out, pad_oe_n;
  logic [7:0] rdv;
  int n_errors = 0, comparisons = 0;

  pmugp_top u_pmugp_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .otp_valid, .otp_defaults, .sleep_state, .seq_drive_en, .led_channel_a_output,
    .pad_in, .pad_out, .pad_oe_n, .pulldown_en);

  initial forever #5 pclk = ~pclk;

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // one apb transfer; idle edge after release so psel is never assigned twice in a step
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_errors++;
      wrap_up();
    end
    rdv = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    chk($sformatf("read %h", a), rdv, exp);
  endtask : rd

  task automatic t_defaults();
    rd(PMUGP_PIN1_ADDR, 8'h00);
    rd(PMUGP_PIN3_ADDR, 8'h00);
    otp_defaults <= 24'hFFFFFF;
    otp_valid <= 1'b1;
    @(posedge pclk);
    otp_valid <= 1'b0;
    rd(PMUGP_PIN1_ADDR, 8'h95);
    rd(PMUGP_PIN2_ADDR, 8'h95);
    rd(PMUGP_PIN3_ADDR, 8'hFD);
    apb(1'b0, 12'h200, 8'h00);
    chk("unmapped error", {7'h0, err}, 8'h01);
    $display("defaults done");
  endtask : t_defaults

  task automatic t_drive();
    seq_drive_en <= 3'b111;
    apb(1'b1, PMUGP_PIN1_ADDR, 8'hFF);
    rd(PMUGP_PIN1_ADDR, 8'h95);
    apb(1'b1, PMUGP_PIN1_ADDR, 8'h05);
    apb(1'b1, PMUGP_PIN2_ADDR, 8'h04);
    apb(1'b1, PMUGP_PIN3_ADDR, 8'h00);
    cyc(2);
    chk("oe_n", {5'h0, pad_oe_n}, 8'h04);
    chk("out", {5'h0, pad_out}, 8'h01);
    seq_drive_en <= 3'b110;
    cyc(2);
    chk("oe_n held", {5'h0, pad_oe_n}, 8'h05);
    seq_drive_en <= 3'b111;
    sleep_state <= 1'b1;
    apb(1'b1, PMUGP_PIN1_ADDR, 8'h85);
    cyc(2);
    chk("sleep low", {7'h0, pad_out[0]}, 8'h00);
    apb(1'b1, PMUGP_PIN1_ADDR, 8'h05);
    cyc(2);
    chk("sleep kept", {7'h0, pad_out[0]}, 8'h01);
    sleep_state <= 1'b0;
    $display("drive done");
  endtask : t_drive

  // pin 3 extras: led source, open drain, pulldown
  task automatic t_pin3();
    apb(1'b1, PMUGP_PIN3_ADDR, 8'h45);
    led_channel_a_output <= 1'b1;
    cyc(2);
    chk("led high", {7'h0, pad_out[2]}, 8'h01);
    led_channel_a_output <= 1'b0;
    cyc(2);
    chk("led low", {7'h0, pad_out[2]}, 8'h00);
    apb(1'b1, PMUGP_PIN3_ADDR, 8'h25);
    cyc(2);
    chk("od release", {7'h0, pad_oe_n[2]}, 8'h01);
    apb(1'b1, PMUGP_PIN3_ADDR, 8'h24);
    cyc(2);
    chk("od sink", {6'h0, pad_oe_n[2], pad_out[2]}, 8'h00);
    apb(1'b1, PMUGP_PIN3_ADDR, 8'h08);
    cyc(2);
    chk("pulldown", {7'h0, pulldown_en}, 8'h01);
    rd(PMUGP_PIN3_ADDR, 8'h08);
    $display("pin3 done");
  endtask : t_pin3

  // glitch on pin 2 restarts its long filter
  task automatic t_filter();
    apb(1'b1, PMUGP_PIN1_ADDR, 8'h00);
    apb(1'b1, PMUGP_PIN2_ADDR, 8'h10);
    pad_in <= 3'b011;
    cyc(5000);
    pad_in <= 3'b001;
    cyc(10);
    pad_in <= 3'b011;
    cyc(4290);
    rd(PMUGP_PIN1_ADDR, 8'h00);
    cyc(200);
    rd(PMUGP_PIN1_ADDR, 8'h02);
    cyc(6200);
    rd(PMUGP_PIN2_ADDR, 8'h10);
    cyc(5000);
    rd(PMUGP_PIN2_ADDR, 8'h12);
    presetn <= 1'b0;
    cyc(3);
    presetn <= 1'b1;
    rd(PMUGP_PIN2_ADDR, 8'h00);
    $display("filter done");
  endtask : t_filter

  initial begin
    cyc(12);
    presetn <= 1'b1;
    t_defaults();
    t_drive();
    t_pin3();
    t_filter();
    wrap_up();
  end
endmodule : tb_pmugp_top
`default_nettype wire
